// ==== bench/codec_partner.sv ====
// Behavioural external codec: bit clock, frame sync and serial data source.
`timescale 1ns/1ps
module codec_partner (
   // Run request from the bench.
   input wire logic run,
   // Lines toward the device.
   output logic bclk,
   output logic fs,
   output logic sdi
);
   int bit_cnt;

   // Clock stands still low while run is low; 64 ns period while running.
   initial begin
      bclk = 1'b0;
      forever begin
         #32;
         bclk = run ? ~bclk : 1'b0;
      end
   end

   // Sync marks the first bit of each 16-bit frame; data toggles every bit.
   initial begin
      bit_cnt = 0;
      fs = 1'b0;
      sdi = 1'b0;
      forever begin
         @(negedge bclk);
         fs = (bit_cnt == 0);
         sdi = ~sdi;
         bit_cnt = (bit_cnt + 1) % 16;
      end
   end
endmodule

// ==== bench/tb_top.sv ====
// Self-checking bench for the codec serial interface.
`timescale 1ns/1ps
module tb_top import codec_pkg::*;;
   logic clk, rst, cpu_idle, reg_wr, reg_rd, ext_run;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic bclk_out, bclk_oe, fs_out, fs_oe, sdo, sdo_oe, group_done;
   logic ext_bclk, ext_fs, ext_sdi;
   int errors, checks_done;

   // The bit clock and frame sync pin inputs see whichever party currently drives the line; data in always comes from the codec.
   codec_serial_interface DUT (.clk(clk), .rst(rst), .ce(1'b1), .cpu_idle(cpu_idle),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .serial_bit_clock_in(bclk_oe ? bclk_out : ext_bclk),
      .serial_bit_clock_out(bclk_out), .serial_bit_clock_oe(bclk_oe),
      .frame_sync_pin_in(fs_oe ? fs_out : ext_fs), .frame_sync_pin_out(fs_out),
      .frame_sync_pin_oe(fs_oe), .serial_data_in(ext_sdi), .serial_data_out(sdo),
      .serial_data_oe(sdo_oe), .group_done(group_done));
   codec_partner codec (.run(ext_run), .bclk(ext_bclk), .fs(ext_fs), .sdi(ext_sdi));

   // System clock, 8 ns period.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic wrap_up();
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Register port cycles; read data is taken in the one cycle it stands.
   // A write leaves one idle edge behind it, so two writes never reassign the strobe at once.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      chk(reg_rdata, exp);
   endtask

   // Bounded wait for the group pulse, so a stuck sequencer cannot hang the run.
   task automatic wait_done();
      int i;
      i = 0;
      while (group_done !== 1'b1 && i < 5000) begin
         @(posedge clk);
         i++;
      end
      chk({15'h0, i < 5000}, 16'h0001);
      @(posedge clk);
   endtask

   task automatic t_regs();
      // After reset only the transmit-empty status bit is set, since no buffer holds data.
      for (int a = 0; a < 8; a++) rchk(4'(a), {15'h0, 4'(a) == STATUS_OFS});
      wr(MODE_OFS, 16'h7fff);
      rchk(MODE_OFS, 16'h2fe3);
      chk({13'h0, bclk_oe, fs_oe, sdo_oe}, 16'h0000);
      wr(FRAME_OFS, 16'hffff);
      rchk(FRAME_OFS, 16'h0def);
      wr(4'h6, 16'hffff);
      rchk(4'h6, 16'h0000);
      wr(MODE_OFS, 16'h0000);
   endtask

   // One word per group over loopback; the second group underflows.
   task automatic t_loop(input logic [15:0] m, input logic [15:0] d, input logic [15:0] e2);
      wr(FRAME_OFS, 16'h000f);
      wr(TXEN_OFS, 16'h0001);
      wr(RXEN_OFS, 16'h0001);
      wr(4'h8, d);
      wr(MODE_OFS, 16'h8820 | m);
      wait_done();
      rchk(4'hc, d);
      chk({15'h0, bclk_oe}, {15'h0, ~m[10]});
      chk({15'h0, fs_oe}, {15'h0, ~m[8]});
      wait_done();
      // Second group left unread data, an underflow and empty transmit buffers.
      rchk(STATUS_OFS, 16'h0007);
      rchk(4'hc, e2);
      wr(MODE_OFS, 16'h0000);
   endtask

   // Receive from the codec's data pin with loopback off; its bits alternate, zero first.
   task automatic t_ext_rx();
      wr(MODE_OFS, 16'h8720);
      wait_done();
      rchk(4'hc, 16'h5555);
      wr(MODE_OFS, 16'h0000);
   endtask

   task automatic t_slot_off(input logic b6);
      int n;
      n = 0;
      wr(TXEN_OFS, 16'h0000);
      wr(MODE_OFS, 16'h8000 | {9'h0, b6, 6'h0});
      repeat (8) @(posedge clk);
      repeat (200) begin
         @(posedge clk);
         n += int'((sdo_oe !== !b6) || (!b6 && sdo !== 1'b0));
      end
      chk(16'(n), 16'h0000);
      wr(MODE_OFS, 16'h0000);
   endtask

   task automatic t_framing();
      int i;
      // Two slots per frame, so the odd-slot sync of I2S framing has a slot to mark.
      wr(FRAME_OFS, 16'h002f);
      for (int m = 0; m < 4; m++) begin
         wr(MODE_OFS, 16'h8000 | 16'(m));
         i = 0;
         while (fs_out !== 1'b1 && i < 2000) begin
            @(posedge clk);
            i++;
         end
         chk({14'h0, fs_oe, i < 2000}, 16'h0003);
         wr(MODE_OFS, 16'h0000);
      end
   endtask

   task automatic t_stop_idle();
      int n;
      logic b;
      cpu_idle <= 1'b1;
      wr(MODE_OFS, 16'ha000);
      repeat (4) @(posedge clk);
      b = bclk_out;
      n = 0;
      repeat (100) begin
         @(posedge clk);
         n += int'(bclk_out !== b);
      end
      chk(16'(n), 16'h0000);
      cpu_idle <= 1'b0;
      repeat (100) begin
         @(posedge clk);
         n += int'(bclk_out !== b);
      end
      chk({15'h0, n > 0}, 16'h0001);
      wr(MODE_OFS, 16'h0000);
   endtask

   // Cuts a hang short well beyond the expected run length.
   initial begin
      #400000;
      errors++;
      wrap_up();
   end

   // Reset, then the scenarios in turn.
   initial begin
      {rst, cpu_idle, reg_wr, reg_rd, ext_run} = 5'b10000;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      errors = 0;
      checks_done = 0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_loop(16'h0000, 16'ha5c3, 16'h0000);
      t_loop(16'h0080, 16'h3c96, 16'h3c96);
      ext_run <= 1'b1;
      t_loop(16'h0700, 16'h5a0f, 16'h0000);
      t_ext_rx();
      ext_run <= 1'b0;
      t_slot_off(1'b1);
      t_slot_off(1'b0);
      t_framing();
      t_stop_idle();
      wrap_up();
   end
endmodule

// ==== design/codec_pin_sync.sv ====
// Three-stage synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ps
module codec_pin_sync import codec_pkg::*; #(
   parameter int WIDTH = 1
) (
   // Clock, reset and freeze.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Raw and filtered levels.
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] stable_out
);

   logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, stable_reg, stable_next;

   // A bit follows the pin only when stages two and three agree, which rejects one-cycle glitches.
   always_comb begin
      stable_next = stable_reg;
      for (int i = 0; i < WIDTH; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            stable_next[i] = s3_reg[i];
         end
      end
   end

   // Stage one is read by stage two only.
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         stable_reg <= '0;
      end else if (ce) begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         stable_reg <= stable_next;
      end
   end

   assign stable_out = stable_reg;

endmodule

// ==== design/codec_pkg.sv ====
// Shared constants and types for the codec serial interface.
package codec_pkg;

   // Register port geometry.
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // Register word addresses.
   localparam logic [3:0] MODE_OFS = 4'h0;
   localparam logic [3:0] FRAME_OFS = 4'h1;
   localparam logic [3:0] CLKDIV_OFS = 4'h2;
   localparam logic [3:0] STATUS_OFS = 4'h3;
   localparam logic [3:0] RXEN_OFS = 4'h4;
   localparam logic [3:0] TXEN_OFS = 4'h5;
   localparam logic [1:0] TXBUF_PAGE = 2'h2;
   localparam logic [1:0] RXBUF_PAGE = 2'h3;

   // Values after reset.
   localparam logic [15:0] MODE_RST = 16'h0000;
   localparam logic [15:0] FRAME_RST = 16'h0000;
   localparam logic [15:0] CLKDIV_RST = 16'h0000;
   localparam logic [15:0] SLOT_EN_RST = 16'h0000;

   // Writable bits of each register; the rest read as zero.
   localparam logic [15:0] MODE_MASK = 16'hafe3;
   localparam logic [15:0] FRAME_MASK = 16'h0def;
   localparam logic [15:0] CLKDIV_MASK = 16'h0fff;

   // Mode control fields.
   localparam int ENABLE_BIT = 15;
   localparam int IDLE_STOP_BIT = 13;
   localparam int LOOP_BIT = 11;
   localparam int BCLK_DIR_BIT = 10;
   localparam int EDGE_BIT = 9;
   localparam int FS_DIR_BIT = 8;
   localparam int UNF_BIT = 7;
   localparam int SDOM_BIT = 6;
   localparam int JUSTIFY_BIT = 5;
   localparam int FRAMING_LSB = 0;

   // Frame format fields.
   localparam int BUFFER_LENGTH_LSB = 10;
   localparam int FLEN_LSB = 5;
   localparam int WS_LSB = 0;

   // Status fields.
   localparam int SLOT_LSB = 8;
   localparam int ROV_BIT = 3;
   localparam int RFUL_BIT = 2;
   localparam int TRANSMIT_UNDERFLOW_FLAG_BIT = 1;
   localparam int TMPTY_BIT = 0;

   // Synchroniser depth for pin inputs.
   localparam int SYNC_DEPTH = 3;

   typedef enum logic [1:0] {
      FRAME_MULTI = 2'b00,
      FRAME_I2S = 2'b01,
      FRAME_AC16 = 2'b10,
      FRAME_AC20 = 2'b11
   } framing_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_LEAD = 2'b10,
      ST_SHIFT = 2'b11
   } seq_state_t;

endpackage

// ==== design/codec_serial_interface.sv ====
// Codec serial interface: registers, bit clock, frame sequencer and pins.
`timescale 1ns/1ps
module codec_serial_interface import codec_pkg::*; #(
   parameter int DIV_W = 12
) (
   // Clock, reset and freeze.
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Processor power state.
   input wire logic cpu_idle,
   // Register port.
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Serial bit clock pin.
   input wire logic serial_bit_clock_in,
   output logic serial_bit_clock_out,
   output logic serial_bit_clock_oe,
   // Frame sync pin.
   input wire logic frame_sync_pin_in,
   output logic frame_sync_pin_out,
   output logic frame_sync_pin_oe,
   // Serial data pins.
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_oe,
   // One-cycle pulse when a buffer group has been moved.
   output logic group_done
);

   generate
      if (DIV_W < 1 || DIV_W > 12) begin : g_bad_div
         $error("DIV_W must lie between 1 and 12");
      end
   endgenerate

   // Justifies a word so that its first bit sits in bit 15.
   function automatic logic [15:0] msb_align(input logic [15:0] w, input logic [3:0] ws);
      return w << (4'd15 - ws);
   endfunction

   logic [15:0] mode_reg, mode_next, frame_reg, frame_next, div_reg, div_next;
   logic [15:0] rxen_reg, rxen_next, txen_reg, txen_next, last_reg, last_next;
   logic [15:0] txbuf_reg [4], txbuf_next [4], rxbuf_reg [4], rxbuf_next [4];
   logic [3:0] txv_reg, txv_next, rxu_reg, rxu_next;
   logic rov_reg, rov_next, transmit_underflow_flag_reg, transmit_underflow_flag_next, rful_reg, rful_next;
   logic [15:0] rdata_reg, rdata_next, txs_reg, txs_next, rxs_reg, rxs_next, word;
   seq_state_t st_reg, st_next;
   logic [3:0] slot_reg, slot_next, bit_reg, bit_next;
   logic [1:0] idx_reg, idx_next;
   logic fs_seen_reg, fs_seen_next, fsprev_reg, fsprev_next;
   logic fs_reg, fs_next, fs_oe_reg, fs_oe_next, sdo_reg, sdo_next, sdo_oe_reg, sdo_oe_next;
   logic gdone_reg, gdone_next;
   logic [DIV_W-1:0] dcnt_reg, dcnt_next;
   logic bclk_reg, bclk_next, bclk_oe_reg, bclk_oe_next, bprev_reg, bprev_next;
   logic rise_reg, rise_next, fall_reg, fall_next;
   logic [2:0] pin_s;
   logic en, run, bdir, fsdir, just, launch, sample, din;
   logic slot_end, frame_end, start, load, load_unf, tx_on;
   logic [3:0] ws, flen;
   logic [1:0] buffer_length;
   framing_t framing;

   // Pins from the codec are filtered before any edge is looked for.
   codec_pin_sync #(.WIDTH(3)) u_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .async_in({serial_bit_clock_in, frame_sync_pin_in, serial_data_in}),
      .stable_out(pin_s)
   );

   // Field decode of the control registers.
   assign en = mode_reg[ENABLE_BIT];
   assign run = en && !(mode_reg[IDLE_STOP_BIT] && cpu_idle);
   assign bdir = mode_reg[BCLK_DIR_BIT];
   assign fsdir = mode_reg[FS_DIR_BIT];
   assign just = mode_reg[JUSTIFY_BIT];
   assign framing = framing_t'(mode_reg[FRAMING_LSB+:2]);
   assign buffer_length = frame_reg[BUFFER_LENGTH_LSB+:2];
   assign flen = frame_reg[FLEN_LSB+:4];
   assign ws = frame_reg[WS_LSB+:4];
   assign launch = mode_reg[EDGE_BIT] ? fall_reg : rise_reg;
   assign sample = mode_reg[EDGE_BIT] ? rise_reg : fall_reg;
   assign din = mode_reg[LOOP_BIT] ? sdo_reg : pin_s[0];

   // Bit clock: divide the system clock when driving, find synced edges when receiving.
   always_comb begin
      dcnt_next = dcnt_reg;
      bclk_next = bclk_reg;
      rise_next = 1'b0;
      fall_next = 1'b0;
      bprev_next = pin_s[2];
      bclk_oe_next = en && !bdir;
      if (!run) begin
         dcnt_next = '0;
         bclk_next = 1'b0;
      end else if (bdir) begin
         rise_next = pin_s[2] && !bprev_reg;
         fall_next = !pin_s[2] && bprev_reg;
      end else if (dcnt_reg == div_reg[DIV_W-1:0]) begin
         dcnt_next = '0;
         bclk_next = !bclk_reg;
         rise_next = !bclk_reg;
         fall_next = bclk_reg;
      end else begin
         dcnt_next = dcnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dcnt_reg <= '0;
         bclk_reg <= 1'b0;
         bclk_oe_reg <= 1'b0;
         bprev_reg <= 1'b0;
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
      end else if (ce) begin
         dcnt_reg <= dcnt_next;
         bclk_reg <= bclk_next;
         bclk_oe_reg <= bclk_oe_next;
         bprev_reg <= bprev_next;
         rise_reg <= rise_next;
         fall_reg <= fall_next;
      end
   end

   // Register port, buffers and frame sequencer; hardware sets come last so they beat clears.
   always_comb begin
      mode_next = mode_reg;
      frame_next = frame_reg;
      div_next = div_reg;
      rxen_next = rxen_reg;
      txen_next = txen_reg;
      last_next = last_reg;
      txbuf_next = txbuf_reg;
      rxbuf_next = rxbuf_reg;
      txv_next = txv_reg;
      rxu_next = rxu_reg;
      rov_next = rov_reg;
      transmit_underflow_flag_next = transmit_underflow_flag_reg;
      rful_next = rful_reg;
      rdata_next = '0;
      st_next = st_reg;
      slot_next = slot_reg;
      bit_next = bit_reg;
      idx_next = idx_reg;
      txs_next = txs_reg;
      rxs_next = rxs_reg;
      fs_seen_next = fs_seen_reg;
      fsprev_next = fsprev_reg;
      fs_next = fs_reg;
      sdo_next = sdo_reg;
      sdo_oe_next = sdo_oe_reg;
      fs_oe_next = en && !fsdir;
      gdone_next = 1'b0;
      slot_end = 1'b0;
      frame_end = 1'b0;
      start = 1'b0;
      load = 1'b0;
      load_unf = 1'b0;
      tx_on = 1'b0;
      word = '0;
      if (reg_wr) begin
         case (reg_addr)
            MODE_OFS: mode_next = reg_wdata & MODE_MASK;
            FRAME_OFS: frame_next = reg_wdata & FRAME_MASK;
            CLKDIV_OFS: div_next = reg_wdata & CLKDIV_MASK;
            RXEN_OFS: rxen_next = reg_wdata;
            TXEN_OFS: txen_next = reg_wdata;
            default: begin
               if (reg_addr[3:2] == TXBUF_PAGE) begin
                  txbuf_next[reg_addr[1:0]] = reg_wdata;
                  txv_next[reg_addr[1:0]] = 1'b1;
                  last_next = reg_wdata;
               end
            end
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            MODE_OFS: rdata_next = mode_reg;
            FRAME_OFS: rdata_next = frame_reg;
            CLKDIV_OFS: rdata_next = div_reg;
            RXEN_OFS: rdata_next = rxen_reg;
            TXEN_OFS: rdata_next = txen_reg;
            STATUS_OFS: begin
               rdata_next[SLOT_LSB+:4] = slot_reg;
               rdata_next[ROV_BIT] = rov_reg;
               rdata_next[RFUL_BIT] = rful_reg;
               rdata_next[TRANSMIT_UNDERFLOW_FLAG_BIT] = transmit_underflow_flag_reg;
               rdata_next[TMPTY_BIT] = ~|txv_reg;
               rov_next = 1'b0;
               transmit_underflow_flag_next = 1'b0;
            end
            default: begin
               if (reg_addr[3:2] == TXBUF_PAGE) begin
                  rdata_next = txbuf_reg[reg_addr[1:0]];
               end else if (reg_addr[3:2] == RXBUF_PAGE) begin
                  rdata_next = rxbuf_reg[reg_addr[1:0]];
                  rxu_next[reg_addr[1:0]] = 1'b0;
                  rful_next = 1'b0;
               end
            end
         endcase
      end
      if (!en) begin
         st_next = ST_IDLE;
         slot_next = '0;
         bit_next = '0;
         idx_next = '0;
         fs_seen_next = 1'b0;
         fs_next = 1'b0;
         sdo_next = 1'b0;
         sdo_oe_next = 1'b0;
      end else if (run) begin
         if (st_reg == ST_IDLE) begin
            st_next = ST_WAIT;
         end
         if (sample) begin
            fsprev_next = pin_s[1];
            if (fsdir && pin_s[1] && !fsprev_reg) begin
               fs_seen_next = 1'b1;
            end
            if (st_reg == ST_SHIFT) begin
               rxs_next = {rxs_reg[14:0], din};
            end
         end
         if (launch && st_reg != ST_IDLE) begin
            slot_end = (st_reg == ST_SHIFT) && (bit_reg == 4'h0);
            if (slot_end) begin
               if (rxen_reg[slot_reg]) begin
                  rxbuf_next[idx_reg] = rxs_reg & (16'hffff >> (4'd15 - ws));
                  if (rxu_reg[idx_reg]) begin
                     rov_next = 1'b1;
                  end
                  rxu_next[idx_reg] = 1'b1;
               end
               if (rxen_reg[slot_reg] || txen_reg[slot_reg]) begin
                  if (idx_reg == buffer_length) begin
                     idx_next = '0;
                     gdone_next = 1'b1;
                     rful_next = 1'b1;
                  end else begin
                     idx_next = idx_reg + 2'd1;
                  end
               end
            end
            frame_end = slot_end && (slot_reg == flen);
            start = (st_reg == ST_WAIT || frame_end) && (!fsdir || fs_seen_reg);
            if (start) begin
               fs_seen_next = 1'b0;
               slot_next = '0;
               st_next = just ? ST_SHIFT : ST_LEAD;
               load = just;
            end else if (frame_end) begin
               st_next = ST_WAIT;
            end else if (st_reg == ST_LEAD) begin
               st_next = ST_SHIFT;
               load = 1'b1;
            end else if (slot_end) begin
               slot_next = slot_reg + 4'd1;
               load = 1'b1;
            end else if (st_reg == ST_SHIFT) begin
               bit_next = bit_reg - 4'd1;
               txs_next = {txs_reg[14:0], 1'b0};
            end
            if (load) begin
               bit_next = ws;
               txs_next = '0;
               if (txen_reg[slot_next]) begin
                  if (txv_next[idx_next]) begin
                     word = txbuf_next[idx_next];
                  end else begin
                     load_unf = 1'b1;
                     transmit_underflow_flag_next = 1'b1;
                     word = mode_reg[UNF_BIT] ? last_next : 16'h0000;
                  end
                  txv_next[idx_next] = 1'b0;
                  txs_next = msb_align(word, ws);
               end
            end
            tx_on = (st_next == ST_SHIFT) && txen_reg[slot_next];
            sdo_next = tx_on && txs_next[15];
            sdo_oe_next = tx_on || !mode_reg[SDOM_BIT];
            unique case (framing)
               FRAME_MULTI: fs_next = start;
               FRAME_I2S: fs_next = (st_next != ST_WAIT) && slot_next[0];
               FRAME_AC16, FRAME_AC20: fs_next = (st_next != ST_WAIT) && (slot_next == 4'h0);
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_reg <= MODE_RST;
         frame_reg <= FRAME_RST;
         div_reg <= CLKDIV_RST;
         rxen_reg <= SLOT_EN_RST;
         txen_reg <= SLOT_EN_RST;
         last_reg <= '0;
         txbuf_reg <= '{default: '0};
         rxbuf_reg <= '{default: '0};
         txv_reg <= '0;
         rxu_reg <= '0;
         rov_reg <= 1'b0;
         transmit_underflow_flag_reg <= 1'b0;
         rful_reg <= 1'b0;
         rdata_reg <= '0;
         st_reg <= ST_IDLE;
         slot_reg <= '0;
         bit_reg <= '0;
         idx_reg <= '0;
         txs_reg <= '0;
         rxs_reg <= '0;
         fs_seen_reg <= 1'b0;
         fsprev_reg <= 1'b0;
         fs_reg <= 1'b0;
         fs_oe_reg <= 1'b0;
         sdo_reg <= 1'b0;
         sdo_oe_reg <= 1'b0;
         gdone_reg <= 1'b0;
      end else if (ce) begin
         mode_reg <= mode_next;
         frame_reg <= frame_next;
         div_reg <= div_next;
         rxen_reg <= rxen_next;
         txen_reg <= txen_next;
         last_reg <= last_next;
         txbuf_reg <= txbuf_next;
         rxbuf_reg <= rxbuf_next;
         txv_reg <= txv_next;
         rxu_reg <= rxu_next;
         rov_reg <= rov_next;
         transmit_underflow_flag_reg <= transmit_underflow_flag_next;
         rful_reg <= rful_next;
         rdata_reg <= rdata_next;
         st_reg <= st_next;
         slot_reg <= slot_next;
         bit_reg <= bit_next;
         idx_reg <= idx_next;
         txs_reg <= txs_next;
         rxs_reg <= rxs_next;
         fs_seen_reg <= fs_seen_next;
         fsprev_reg <= fsprev_next;
         fs_reg <= fs_next;
         fs_oe_reg <= fs_oe_next;
         sdo_reg <= sdo_next;
         sdo_oe_reg <= sdo_oe_next;
         gdone_reg <= gdone_next;
      end
   end

   // Every output is a flip-flop.
   assign reg_rdata = rdata_reg;
   assign serial_bit_clock_out = bclk_reg;
   assign serial_bit_clock_oe = bclk_oe_reg;
   assign frame_sync_pin_out = fs_reg;
   assign frame_sync_pin_oe = fs_oe_reg;
   assign serial_data_out = sdo_reg;
   assign serial_data_oe = sdo_oe_reg;
   assign group_done = gdone_reg;

   // Checks on the sequencer and pins.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_disabled_quiet: assert property (ce && !en |=> !serial_data_oe && !frame_sync_pin_oe)
      else $error("pins driven while disabled");
   a_idle_halt: assert property (ce && en && mode_reg[IDLE_STOP_BIT] && cpu_idle
      |=> $stable(slot_reg) && $stable(bit_reg))
      else $error("sequencer moved in idle");
   a_loop_route: assert property (ce && run && mode_reg[LOOP_BIT] && sample && st_reg == ST_SHIFT
      |=> rxs_reg[0] == $past(serial_data_out))
      else $error("loopback bit lost");
   a_bclk_dir: assert property (ce |=> serial_bit_clock_oe == $past(en && !bdir))
      else $error("bit clock direction wrong");
   a_fs_dir: assert property (ce |=> frame_sync_pin_oe == $past(en && !fsdir))
      else $error("frame sync direction wrong");
   a_unf_zero: assert property (ce && load_unf && !mode_reg[UNF_BIT] |=> !serial_data_out)
      else $error("underflow did not send zero");
   a_idle_slot: assert property (st_reg == ST_SHIFT && !txen_reg[slot_reg] && mode_reg[SDOM_BIT]
      |-> !serial_data_oe)
      else $error("disabled slot driven");
   a_slot_bound: assert property (st_reg == ST_SHIFT |-> slot_reg <= flen)
      else $error("slot beyond frame length");
   a_group_wrap: assert property (group_done |-> idx_reg == 2'd0 && rful_reg)
      else $error("index not restarted");
   a_status_slot: assert property (ce && reg_rd && reg_addr == STATUS_OFS
      |=> reg_rdata[SLOT_LSB+:4] == $past(slot_reg))
      else $error("slot status wrong");

   c_group: cover property (group_done);
   c_underflow: cover property (ce && load_unf);
   c_overflow: cover property ($rose(rov_reg));
   c_ext_frame: cover property (fsdir && st_reg == ST_WAIT ##1 st_reg == ST_SHIFT);

endmodule
